/* hsc_pkg.sv */
// Constants and carrier types for the counter value load and input filter block
package hsc_pkg;
    localparam int NUM_CH = 4;
    localparam int CLK_KHZ = 40000;
    localparam int FLT_W = 19;
    localparam int DATA_W = 32;

    // Byte offsets inside one channel window, channel in adr[6:5]
    localparam logic [4:0] OFS_DEFAULT = 5'h00;
    localparam logic [4:0] OFS_CHANGED = 5'h04;
    localparam logic [4:0] OFS_COUNT = 5'h08;
    localparam logic [4:0] OFS_FILTER = 5'h0C;
    localparam logic [4:0] OFS_CONTROL = 5'h10;
    localparam logic [4:0] OFS_INPUTS = 5'h14;
    localparam int CH_LSB = 5;

    // Field positions
    localparam int FLD_AB_LSB = 0;
    localparam int FLD_Z_LSB = 4;
    localparam int FLD_CTL_LSB = 8;
    localparam int CTRL_CHG_BIT = 0;
    localparam int CTRL_RDY_BIT = 1;

    // Reset values
    localparam logic [31:0] DEFAULT_RST = 32'h0000_0000;
    localparam logic [31:0] CHANGED_RST = 32'h0000_0000;
    localparam logic [2:0] AB_SEL_RST = 3'h5;
    localparam logic [2:0] Z_SEL_RST = 3'h5;
    localparam logic [3:0] CTL_SEL_RST = 4'h9;
    localparam logic [31:0] FILTER_RST = 32'h0000_0955;
    localparam logic [31:0] FILTER_MASK = 32'h0000_0F77;

    // Time constants, as printed
    localparam int AB_NS [7] = '{0, 100, 200, 500, 1000, 2000, 10000};
    localparam int CTL_US [12] = '{0, 2, 5, 10, 20, 50, 100, 500, 1000, 2000, 5000, 10000};

    // Least times round up to whole cycles
    function automatic int ns_to_cyc(input int ns);
        return (ns * CLK_KHZ + 999999) / 1000000;
    endfunction

    function automatic int us_to_cyc(input int us);
        return (us * CLK_KHZ + 999) / 1000;
    endfunction

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ph_a;
        logic ph_b;
        logic ph_z;
        logic ctl0;
        logic ctl1;
    } hsc_pins_t;
endpackage

/* input_filter.sv */
// Synchroniser and stability filter for one counter input
`timescale 1ns/1ps
module input_filter (
    input wire logic mclk, // Clock
    input wire logic rst_n, // Synchronous reset
    input wire logic raw, // Pin level
    input wire logic [hsc_pkg::FLT_W-1:0] limit, // Stable cycles, zero bypasses
    output logic filt // Filtered level
);
    logic s1;
    logic s2;
    logic [hsc_pkg::FLT_W-1:0] cnt;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
        end else begin
            s1 <= raw;
            s2 <= s1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            filt <= 1'b0;
            cnt <= '0;
        end else if (limit == '0) begin
            filt <= s2;
            cnt <= '0;
        end else if (s2 != filt) begin
            if (cnt >= limit - 1'b1) begin
                filt <= s2;
                cnt <= '0;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end else begin
            cnt <= '0; // Short pulse discarded
        end
    end

    a_bypass_direct: assert property (@(posedge mclk) disable iff (!rst_n)
        limit == '0 |=> filt == $past(s2)) else $error("bypass not direct");

    a_glitch_dropped: assert property (@(posedge mclk) disable iff (!rst_n)
        (limit >= 3 && filt == s2 && $stable(limit)) ##1 (s2 != filt) ##1 (s2 == filt)
        |=> filt == $past(filt, 2)) else $error("short pulse passed");

    a_filter_wait: assert property (@(posedge mclk) disable iff (!rst_n)
        (limit != '0 && $changed(filt) && $past(limit) == limit) |-> $past(cnt) == limit - 1'b1)
        else $error("filter passed early");

    c_filter_pass: cover property (@(posedge mclk) disable iff (!rst_n)
        limit > 1 && $changed(filt));
endmodule // input_filter

/* hsc_load_filter.sv */
// Count value load, change request and input filter top for four channels
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module hsc_load_filter #(
    parameter int CTL_500US_CYC = hsc_pkg::us_to_cyc(hsc_pkg::CTL_US[7]),
    parameter int CTL_1MS_CYC = hsc_pkg::us_to_cyc(hsc_pkg::CTL_US[8]),
    parameter int CTL_2MS_CYC = hsc_pkg::us_to_cyc(hsc_pkg::CTL_US[9]),
    parameter int CTL_5MS_CYC = hsc_pkg::us_to_cyc(hsc_pkg::CTL_US[10]),
    parameter int CTL_10MS_CYC = hsc_pkg::us_to_cyc(hsc_pkg::CTL_US[11])
) (
    input wire logic mclk, // 40 MHz clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire hsc_pkg::wb_req_t wb_req, // Wishbone request group
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire hsc_pkg::hsc_pins_t [hsc_pkg::NUM_CH-1:0] pins, // Field inputs
    input wire logic [hsc_pkg::NUM_CH-1:0] count_up, // Count step up pulses
    input wire logic [hsc_pkg::NUM_CH-1:0] count_dn, // Count step down pulses
    output hsc_pkg::hsc_pins_t [hsc_pkg::NUM_CH-1:0] filt, // Filtered inputs
    output logic [hsc_pkg::NUM_CH-1:0][31:0] count_value, // Current counts
    output logic [hsc_pkg::NUM_CH-1:0] load_pulse // Change load happened
);
    localparam int NCH = hsc_pkg::NUM_CH;

    logic [NCH-1:0][31:0] def_val;
    logic [NCH-1:0][31:0] chg_val;
    logic [NCH-1:0][31:0] filt_cfg;
    logic [NCH-1:0] chg_req;
    logic [NCH-1:0] chg_req_q;
    logic [NCH-1:0] ready;
    logic [NCH-1:0] chg_rise;
    logic [NCH-1:0][31:0] next_count;

    logic req_go;
    logic wr_go;
    logic [1:0] req_ch;
    logic [4:0] req_ofs;
    logic req_hit;
    logic [31:0] next_rdata;

    // Cycle counts for the A, B and Z choices
    function automatic logic [hsc_pkg::FLT_W-1:0] ab_limit(input logic [2:0] s);
        int c;
        c = 0;
        if (s <= 3'h6) begin
            c = hsc_pkg::ns_to_cyc(hsc_pkg::AB_NS[s]);
        end
        return c[hsc_pkg::FLT_W-1:0];
    endfunction

    // Cycle counts for the control input choices
    function automatic logic [hsc_pkg::FLT_W-1:0] ctl_limit(input logic [3:0] s);
        int c;
        c = 0;
        case (s)
            4'h7: c = CTL_500US_CYC;
            4'h8: c = CTL_1MS_CYC;
            4'h9: c = CTL_2MS_CYC;
            4'hA: c = CTL_5MS_CYC;
            4'hB: c = CTL_10MS_CYC;
            default: begin
                if (s <= 4'h6) begin
                    c = hsc_pkg::us_to_cyc(hsc_pkg::CTL_US[s]);
                end
            end
        endcase
        return c[hsc_pkg::FLT_W-1:0];
    endfunction

    // Byte lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Register slot match, byte bits ignored
    function automatic logic hits(input logic [4:0] ofs, input logic [4:0] slot);
        return ofs[4:2] == slot[4:2];
    endfunction

    // Bus decode
    assign req_go = wb_req.cyc && wb_req.stb && !wb_ack_o;
    assign wr_go = req_go && wb_req.we;
    assign req_ch = wb_req.adr[hsc_pkg::CH_LSB +: 2];
    assign req_ofs = wb_req.adr[4:0];
    assign req_hit = !wb_req.adr[7];

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (req_hit) begin
            case ({req_ofs[4:2], 2'b00})
                hsc_pkg::OFS_DEFAULT: next_rdata = def_val[req_ch];
                hsc_pkg::OFS_CHANGED: next_rdata = chg_val[req_ch];
                hsc_pkg::OFS_COUNT: next_rdata = count_value[req_ch];
                hsc_pkg::OFS_FILTER: next_rdata = filt_cfg[req_ch];
                hsc_pkg::OFS_CONTROL: next_rdata = {30'h0, ready[req_ch], chg_req[req_ch]};
                hsc_pkg::OFS_INPUTS: next_rdata = {27'h0, filt[req_ch]};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // One cycle answer, unmapped reads give zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req_go;
            if (req_go && !wb_req.we) begin
                wb_dat_o <= next_rdata;
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            logic sel_me;
            assign sel_me = wr_go && req_hit && req_ch == 2'(ch);
            assign chg_rise[ch] = chg_req[ch] && !chg_req_q[ch];

            // Configuration words; default and changed values kept whole as signed 32 bits, filter word masked by FILTER_MASK
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    def_val[ch] <= hsc_pkg::DEFAULT_RST;
                    chg_val[ch] <= hsc_pkg::CHANGED_RST;
                    filt_cfg[ch] <= hsc_pkg::FILTER_RST;
                end else if (sel_me) begin
                    if (hits(req_ofs, hsc_pkg::OFS_DEFAULT)) begin
                        def_val[ch] <= lane_merge(def_val[ch], wb_req.dat, wb_req.sel);
                    end
                    if (hits(req_ofs, hsc_pkg::OFS_CHANGED)) begin
                        chg_val[ch] <= lane_merge(chg_val[ch], wb_req.dat, wb_req.sel);
                    end
                    if (hits(req_ofs, hsc_pkg::OFS_FILTER)) begin
                        filt_cfg[ch] <= lane_merge(filt_cfg[ch], wb_req.dat,
                                                   wb_req.sel) & hsc_pkg::FILTER_MASK;
                    end
                end
            end

            // Request and ready bits
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    chg_req[ch] <= 1'b0;
                    ready[ch] <= 1'b0;
                    chg_req_q[ch] <= 1'b0;
                end else begin
                    chg_req_q[ch] <= chg_req[ch];
                    if (sel_me && hits(req_ofs, hsc_pkg::OFS_CONTROL) && wb_req.sel[0]) begin
                        chg_req[ch] <= wb_req.dat[hsc_pkg::CTRL_CHG_BIT];
                        ready[ch] <= wb_req.dat[hsc_pkg::CTRL_RDY_BIT];
                    end
                end
            end

            // Count source: default before ready, then load or step
            always_comb begin
                next_count[ch] = count_value[ch];
                if (!ready[ch]) begin
                    next_count[ch] = def_val[ch];
                end else if (chg_rise[ch]) begin
                    next_count[ch] = chg_val[ch];
                end else if (count_up[ch] && !count_dn[ch]) begin
                    next_count[ch] = count_value[ch] + 32'h0000_0001;
                end else if (count_dn[ch] && !count_up[ch]) begin
                    next_count[ch] = count_value[ch] - 32'h0000_0001;
                end
            end

            // Bus writes to the count slot never reach the count; before ready it follows the default word
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    count_value[ch] <= hsc_pkg::DEFAULT_RST;
                    load_pulse[ch] <= 1'b0;
                end else begin
                    count_value[ch] <= next_count[ch];
                    load_pulse[ch] <= ready[ch] && chg_rise[ch];
                end
            end

            // Five filters per channel; A and B share one setting, Z has its own, both control inputs share one
            input_filter u_fa (
                .mclk(mclk), .rst_n(rst_n), .raw(pins[ch].ph_a),
                .limit(ab_limit(filt_cfg[ch][hsc_pkg::FLD_AB_LSB +: 3])), .filt(filt[ch].ph_a)
            );
            input_filter u_fb (
                .mclk(mclk), .rst_n(rst_n), .raw(pins[ch].ph_b),
                .limit(ab_limit(filt_cfg[ch][hsc_pkg::FLD_AB_LSB +: 3])), .filt(filt[ch].ph_b)
            );
            input_filter u_fz (
                .mclk(mclk), .rst_n(rst_n), .raw(pins[ch].ph_z),
                .limit(ab_limit(filt_cfg[ch][hsc_pkg::FLD_Z_LSB +: 3])), .filt(filt[ch].ph_z)
            );
            input_filter u_fc0 (
                .mclk(mclk), .rst_n(rst_n), .raw(pins[ch].ctl0),
                .limit(ctl_limit(filt_cfg[ch][hsc_pkg::FLD_CTL_LSB +: 4])), .filt(filt[ch].ctl0)
            );
            input_filter u_fc1 (
                .mclk(mclk), .rst_n(rst_n), .raw(pins[ch].ctl1),
                .limit(ctl_limit(filt_cfg[ch][hsc_pkg::FLD_CTL_LSB +: 4])), .filt(filt[ch].ctl1)
            );

            a_power_default: assert property (@(posedge mclk) disable iff (!rst_n)
                !ready[ch] |=> count_value[ch] == $past(def_val[ch]))
                else $error("count not at default");

            a_edge_load: assert property (@(posedge mclk) disable iff (!rst_n)
                ready[ch] && chg_req[ch] && !chg_req_q[ch]
                |=> count_value[ch] == $past(chg_val[ch]) && load_pulse[ch])
                else $error("change edge not loaded");

            a_level_noload: assert property (@(posedge mclk) disable iff (!rst_n)
                ready[ch] && chg_req[ch] && chg_req_q[ch] && !count_up[ch] && !count_dn[ch]
                |=> $stable(count_value[ch]) && !load_pulse[ch])
                else $error("held request reloaded");

            a_load_single: assert property (@(posedge mclk) disable iff (!rst_n)
                load_pulse[ch] |=> !load_pulse[ch]) else $error("load pulse held");

            a_monitor_ro: assert property (@(posedge mclk) disable iff (!rst_n)
                ready[ch] && !chg_rise[ch] && !count_up[ch] && !count_dn[ch]
                && sel_me && hits(req_ofs, hsc_pkg::OFS_COUNT)
                |=> $stable(count_value[ch])) else $error("monitor write changed count");

            a_count_after: assert property (@(posedge mclk) disable iff (!rst_n)
                load_pulse[ch] && ready[ch] && !chg_rise[ch] && count_up[ch] && !count_dn[ch]
                |=> count_value[ch] == $past(count_value[ch]) + 32'h0000_0001)
                else $error("count did not continue");

            a_step_down: assert property (@(posedge mclk) disable iff (!rst_n)
                ready[ch] && !chg_rise[ch] && count_dn[ch] && !count_up[ch]
                |=> count_value[ch] == $past(count_value[ch]) - 32'h0000_0001)
                else $error("count did not step down");

            a_count_hold: assert property (@(posedge mclk) disable iff (!rst_n)
                ready[ch] && !chg_rise[ch] && count_up[ch] == count_dn[ch]
                |=> $stable(count_value[ch])) else $error("count moved without step");

            a_reset_cfg: assert property (@(posedge mclk)
                !rst_n |=> def_val[ch] == hsc_pkg::DEFAULT_RST
                && filt_cfg[ch] == hsc_pkg::FILTER_RST) else $error("config reset wrong");

            a_cfg_own_ch: assert property (@(posedge mclk) disable iff (!rst_n)
                wr_go && req_ch != 2'(ch) |=> $stable(filt_cfg[ch]) && $stable(def_val[ch]))
                else $error("write reached other channel");

            a_unmapped_drop: assert property (@(posedge mclk) disable iff (!rst_n)
                wr_go && !req_hit |=> $stable(chg_val[ch]) && $stable(chg_req[ch]))
                else $error("unmapped write stored");

            a_ctrl_lane: assert property (@(posedge mclk) disable iff (!rst_n)
                sel_me && hits(req_ofs, hsc_pkg::OFS_CONTROL) && !wb_req.sel[0]
                |=> $stable(chg_req[ch]) && $stable(ready[ch]))
                else $error("control bits changed without lane");

            c_load_seen: cover property (@(posedge mclk) disable iff (!rst_n)
                load_pulse[ch] && count_up[ch]);

            c_held_request: cover property (@(posedge mclk) disable iff (!rst_n)
                ready[ch] && chg_req[ch] && chg_req_q[ch]);
        end
    endgenerate

    a_ack_single: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

    a_ack_answer: assert property (@(posedge mclk) disable iff (!rst_n)
        req_go |=> wb_ack_o) else $error("request not answered");

    a_read_data: assert property (@(posedge mclk) disable iff (!rst_n)
        req_go && !wb_req.we |=> wb_dat_o == $past(next_rdata)) else $error("read data wrong");

    a_dat_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !(req_go && !wb_req.we) |=> $stable(wb_dat_o)) else $error("read data not held");

    a_ab_two_us: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |-> ab_limit(3'h5) == 19'h00050 && ab_limit(3'h0) == 19'h00000)
        else $error("a b filter map wrong");

    a_ab_range: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |-> ab_limit(3'h1) == 19'h00004 && ab_limit(3'h6) == 19'h00190
        && ab_limit(3'h7) == 19'h00000) else $error("a b filter range wrong");

    a_ctl_two_us: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |-> ctl_limit(4'h1) == 19'h00050 && ctl_limit(4'h0) == 19'h00000)
        else $error("control filter map wrong");

    a_ctl_two_ms: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |-> ctl_limit(4'h9) == 19'(CTL_2MS_CYC) && ctl_limit(4'hC) == 19'h00000)
        else $error("control default map wrong");

    c_wb_write: cover property (@(posedge mclk) disable iff (!rst_n)
        wr_go ##1 wb_ack_o);
    c_wb_read: cover property (@(posedge mclk) disable iff (!rst_n)
        req_go && !wb_req.we ##1 wb_ack_o);
endmodule // hsc_load_filter

/* field_model.sv */
// Field side model: encoder phases and control inputs for every channel
`timescale 1ns/1ps
module field_model (
    input wire logic mclk, // Clock
    output hsc_pkg::hsc_pins_t [hsc_pkg::NUM_CH-1:0] pins // Field inputs
);
    logic [4:0] lv [hsc_pkg::NUM_CH];

    initial begin
        for (int i = 0; i < hsc_pkg::NUM_CH; i++) begin
            lv[i] = 5'h00;
        end
    end

    always_comb begin
        for (int i = 0; i < hsc_pkg::NUM_CH; i++) begin
            pins[i] = lv[i];
        end
    end

    // High pulse of len cycles on one pin, changed just after the edge
    task automatic pulse(input int ch, input int idx, input int len);
        @(posedge mclk);
        lv[ch][idx] <= 1'b1;
        repeat (len) @(posedge mclk);
        lv[ch][idx] <= 1'b0;
    endtask
endmodule // field_model

/* counter_value_load_and_input_filter_tb.sv */
// Testbench for the count load and input filter block
`timescale 1ns/1ps
module counter_value_load_and_input_filter_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    hsc_pkg::wb_req_t wb_req = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    hsc_pkg::hsc_pins_t [hsc_pkg::NUM_CH-1:0] pins;
    logic [hsc_pkg::NUM_CH-1:0] count_up = 4'h0;
    logic [hsc_pkg::NUM_CH-1:0] count_dn = 4'h0;
    hsc_pkg::hsc_pins_t [hsc_pkg::NUM_CH-1:0] filt;
    logic [hsc_pkg::NUM_CH-1:0][31:0] count_value;
    logic [hsc_pkg::NUM_CH-1:0] load_pulse;
    int bad_count = 0;
    int n_compared = 0;
    int loads = 0;
    logic [31:0] rd;
    logic seen;
    // Filter cases: channel, pin index, pulse length, watch span, passes
    int f_ch [9] = '{2, 2, 2, 2, 2, 3, 3, 3, 3};
    int f_idx [9] = '{4, 4, 2, 1, 1, 3, 2, 0, 0};
    int f_len [9] = '{2, 10, 1, 10, 30, 40, 40, 30, 50};
    int f_win [9] = '{12, 16, 8, 30, 40, 60, 60, 50, 70};
    logic f_exp [9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

    always #12.5 mclk = ~mclk;

    hsc_load_filter #(.CTL_500US_CYC(20), .CTL_1MS_CYC(30), .CTL_2MS_CYC(40),
        .CTL_5MS_CYC(50), .CTL_10MS_CYC(60)) hsc_load_filter_i (
        .mclk(mclk), .rst_n(rst_n), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pins(pins), .count_up(count_up), .count_dn(count_dn),
        .filt(filt), .count_value(count_value), .load_pulse(load_pulse));

    field_model field_model_i (.mclk(mclk), .pins(pins));

    always @(posedge mclk) begin
        if (load_pulse[0] === 1'b1) begin
            loads++;
        end
    end

    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One classic cycle; held until ack is sampled high
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge mclk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_req <= '0;
        if (wb_ack_o !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED wb_ack expected 1 seen timeout");
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, adr, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb_cycle(1'b0, adr, 32'h0000_0000, q);
        check(name, q, exp);
    endtask

    // Pulse one pin and note whether the filtered level ever rose
    task automatic watch(input int k, output logic s);
        logic [4:0] fv;
        s = 1'b0;
        fork
            field_model_i.pulse(f_ch[k], f_idx[k], f_len[k]);
            repeat (f_win[k]) begin
                @(posedge mclk);
                fv = filt[f_ch[k]];
                s = s | fv[f_idx[k]];
            end
        join
        repeat (100) @(posedge mclk);
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        // Reset values
        rd_chk("default0", 8'h00, 32'h0000_0000);
        rd_chk("changed0", 8'h04, 32'h0000_0000);
        rd_chk("filter0", 8'h0C, hsc_pkg::FILTER_RST);
        rd_chk("count0", 8'h08, 32'h0000_0000);
        $display("test reset values done");
        // Count follows the power-on default before ready
        wr(8'h20, 32'h8000_0000);
        repeat (3) @(posedge mclk);
        check("count1_default", count_value[1], 32'h8000_0000);
        wr(8'h28, 32'h0000_1234);
        rd_chk("count1_ro", 8'h28, 32'h8000_0000);
        wr(8'h9C, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h9C, 32'h0000_0000);
        $display("test power-on default done");
        // Changed value loaded on request edge only
        wr(8'h04, 32'h7FFF_FFFF);
        wr(8'h10, 32'h0000_0002);
        wr(8'h10, 32'h0000_0003);
        repeat (3) @(posedge mclk);
        check("count0_load", count_value[0], 32'h7FFF_FFFF);
        wr(8'h04, 32'h0000_0005);
        wr(8'h10, 32'h0000_0003);
        repeat (3) @(posedge mclk);
        check("count0_held", count_value[0], 32'h7FFF_FFFF);
        count_dn <= 4'h1;
        @(posedge mclk);
        count_dn <= 4'h0;
        repeat (3) @(posedge mclk);
        check("count0_step", count_value[0], 32'h7FFF_FFFE);
        rd_chk("count0_read", 8'h08, 32'h7FFF_FFFE);
        wr(8'h08, 32'h0000_1234);
        rd_chk("count0_ro", 8'h08, 32'h7FFF_FFFE);
        wr(8'h10, 32'h0000_0002);
        wr(8'h10, 32'h0000_0003);
        // Step lands in the cycle right after the load
        count_up <= 4'h1;
        @(posedge mclk);
        count_up <= 4'h0;
        repeat (3) @(posedge mclk);
        check("count0_reload", count_value[0], 32'h0000_0006);
        check("load_pulses", 32'(loads), 32'h0000_0002);
        $display("test change request done");
        // Filters: ch2 at 4 cycles A/B, Z bypass, control 20; ch3 at defaults
        wr(8'h4C, 32'h0000_0701);
        rd_chk("filter2", 8'h4C, 32'h0000_0701);
        for (int k = 0; k < 9; k++) begin
            watch(k, seen);
            check($sformatf("filt_case%0d", k), {31'h0, seen}, {31'h0, f_exp[k]});
        end
        rd_chk("inputs2_idle", 8'h54, 32'h0000_0000);
        $display("test input filters done");
        end_of_test();
    end
endmodule // counter_value_load_and_input_filter_tb
